// [core/aphs_pkg.sv]
/*
  Shared constants for the parallel host sequencer of the converter.
  Assumes a single 40 MHz clock and a synchronous active-high reset.
*/
package aphs_pkg;
  localparam int unsigned CLK_PERIOD_PS     = 25000;
  localparam int unsigned DATA_WIDTH        = 12;
  localparam int unsigned CTRL_WIDTH        = 8;
  localparam int unsigned RD_FLAG_MAX_NS    = 120;
  localparam int unsigned RD_FLAG_CYCLES    = (RD_FLAG_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned RELEASE_MAX_NS    = 70;
  localparam int unsigned RELEASE_CYCLES    = (RELEASE_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned INT_CLK_FREQ_KHZ  = 1560;
  localparam int unsigned INT_CLK_DIV       = (40000 + INT_CLK_FREQ_KHZ - 1) / INT_CLK_FREQ_KHZ;
  localparam int unsigned ACQ_CONV_CLOCKS   = 6;
  localparam int unsigned CONV_CLOCKS       = 12;
  localparam int unsigned PWR_HI_POS        = 7;
  localparam int unsigned PWR_LO_POS        = 6;
  localparam int unsigned ACQ_SEL_POS       = 5;
  localparam int unsigned RANGE_POS         = 4;
  localparam int unsigned POLARITY_POS      = 3;
  localparam int unsigned CHAN_MSB_POS      = 2;
  localparam logic [7:0]  CTRL_RESET        = 8'h00;
  localparam logic [11:0] RESULT_RESET      = 12'h000;
  localparam logic [1:0]  PWR_NORMAL_EXT    = 2'h0;
  localparam logic [1:0]  PWR_NORMAL_INT    = 2'h1;
  localparam logic [1:0]  PWR_STANDBY       = 2'h2;
  localparam logic [1:0]  PWR_FULL          = 2'h3;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ACQ_INT,
    SEQ_ACQ_EXT,
    SEQ_CONVERT
  } aphs_state_type;
endpackage : aphs_pkg

// [core/aphs_clk_gen.sv]
/*
  Conversion clock tick source: picks the host clock pin edges or an internal divider.
  Assumes the clock pin is already synchronous to mclk_in.
*/
module aphs_clk_gen
  import aphs_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic int_clk_sel_in,
  input  wire logic conv_clk_pin_in,
  output logic      tick_out
);
  import aphs_pkg::*;

  logic [7:0] div_reg;
  logic       pin_reg;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      div_reg <= 8'h00;
      // Taken as high so that a pin already high at release is not seen as a rising edge.
      pin_reg <= 1'b1;
    end else begin
      pin_reg <= conv_clk_pin_in;
      if (div_reg == 8'(INT_CLK_DIV - 1)) begin
        div_reg <= 8'h00;
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end

  // Tick on each rising edge of the host clock, or on divider wrap.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      tick_out <= 1'b0;
    end else if (int_clk_sel_in) begin
      tick_out <= (div_reg == 8'(INT_CLK_DIV - 1));
    end else begin
      tick_out <= conv_clk_pin_in & ~pin_reg;
    end
  end
endmodule : aphs_clk_gen

// [core/aphs_host_seq.sv]
/*
  Parallel host interface and conversion sequencer of a 12-bit converter.
  Assumes host strobes are synchronous to mclk_in and the data bus is resolved outside.
*/
module aphs_host_seq
  import aphs_pkg::*;
(
  input  wire logic                  mclk_in,
  input  wire logic                  rst_in,
  input  wire logic                  chip_sel_n_in,
  input  wire logic                  wr_n_in,
  input  wire logic                  rd_n_in,
  input  wire logic                  conv_clk_pin_in,
  input  wire logic [DATA_WIDTH-1:0] data_bus_lines_in,
  input  wire logic [DATA_WIDTH-1:0] sar_result_in,
  output logic [DATA_WIDTH-1:0]      data_bus_lines_out,
  output logic                       data_bus_lines_oe_out,
  output logic                       done_n_out,
  output logic                       tracking_out,
  output logic                       converting_out,
  output logic                       int_clk_sel_out,
  output logic                       standby_powerdown_out,
  output logic                       full_powerdown_out,
  output logic                       range_sel_out,
  output logic                       polarity_sel_out,
  output logic [2:0]                 channel_sel_out
);
  import aphs_pkg::*;

  aphs_state_type          state_reg;
  logic [CTRL_WIDTH-1:0]   ctrl_reg;
  logic [DATA_WIDTH-1:0]   result_reg;
  logic [3:0]              tick_cnt_reg;
  logic                    wr_n_reg;
  logic                    rd_n_reg;
  logic                    tick;
  logic                    wr_rise;
  logic                    rd_fall;
  logic                    rd_rise;
  logic [1:0]              pwr_next;

  aphs_clk_gen u_clk_gen (
    .mclk_in         (mclk_in),
    .rst_in          (rst_in),
    .int_clk_sel_in  (int_clk_sel_out),
    .conv_clk_pin_in (conv_clk_pin_in),
    .tick_out        (tick)
  );

  // Write rises and read falls only count while chip select is low; read rises count at any time.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wr_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
    end else begin
      wr_n_reg <= wr_n_in;
      rd_n_reg <= rd_n_in;
    end
  end
  assign wr_rise = ~chip_sel_n_in & wr_n_in & ~wr_n_reg;
  assign rd_fall = ~chip_sel_n_in & ~rd_n_in & rd_n_reg;
  assign rd_rise = rd_n_in & ~rd_n_reg;
  assign pwr_next = data_bus_lines_in[PWR_HI_POS:PWR_LO_POS];

  // Control byte; a second write in external acquisition only ends tracking.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl_reg        <= CTRL_RESET;
      int_clk_sel_out <= 1'b0;
    end else if (wr_rise && state_reg != SEQ_ACQ_EXT && state_reg != SEQ_CONVERT) begin
      ctrl_reg <= data_bus_lines_in[CTRL_WIDTH-1:0];
      if (pwr_next == PWR_NORMAL_EXT || pwr_next == PWR_NORMAL_INT) begin
        int_clk_sel_out <= (pwr_next == PWR_NORMAL_INT);
      end
    end
  end

  // Mode outputs are registered so that every pin comes straight from a flip-flop.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      standby_powerdown_out <= 1'b0;
      full_powerdown_out    <= 1'b0;
      range_sel_out         <= 1'b0;
      polarity_sel_out      <= 1'b0;
      channel_sel_out       <= 3'h0;
    end else begin
      standby_powerdown_out <= (ctrl_reg[PWR_HI_POS:PWR_LO_POS] == PWR_STANDBY);
      full_powerdown_out    <= (ctrl_reg[PWR_HI_POS:PWR_LO_POS] == PWR_FULL);
      range_sel_out         <= ctrl_reg[RANGE_POS];
      polarity_sel_out      <= ctrl_reg[POLARITY_POS];
      channel_sel_out       <= ctrl_reg[CHAN_MSB_POS:0];
    end
  end

  // Sequencer. A power-down write from SEQ_IDLE never starts a conversion, since the core is off.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg    <= SEQ_IDLE;
      tick_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        SEQ_IDLE: begin
          tick_cnt_reg <= 4'h0;
          if (wr_rise && !pwr_next[1]) begin
            if (data_bus_lines_in[ACQ_SEL_POS]) begin
              state_reg <= SEQ_ACQ_EXT;
            end else begin
              state_reg <= SEQ_ACQ_INT;
            end
          end
        end
        SEQ_ACQ_INT: begin
          if (tick) begin
            if (tick_cnt_reg == 4'(ACQ_CONV_CLOCKS - 1)) begin
              tick_cnt_reg <= 4'h0;
              state_reg    <= SEQ_CONVERT;
            end else begin
              tick_cnt_reg <= tick_cnt_reg + 4'h1;
            end
          end
        end
        SEQ_ACQ_EXT: begin
          if (wr_rise) begin
            state_reg <= SEQ_CONVERT;
          end
        end
        SEQ_CONVERT: begin
          if (tick) begin
            if (tick_cnt_reg == 4'(CONV_CLOCKS - 1)) begin
              tick_cnt_reg <= 4'h0;
              state_reg    <= SEQ_IDLE;
            end else begin
              tick_cnt_reg <= tick_cnt_reg + 4'h1;
            end
          end
        end
        default: state_reg <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      tracking_out   <= 1'b0;
      converting_out <= 1'b0;
    end else begin
      tracking_out   <= (state_reg == SEQ_ACQ_INT) || (state_reg == SEQ_ACQ_EXT);
      converting_out <= (state_reg == SEQ_CONVERT);
    end
  end

  logic conv_done;
  assign conv_done = (state_reg == SEQ_CONVERT) && tick && (tick_cnt_reg == 4'(CONV_CLOCKS - 1));

  // Result latch and completion flag; completion wins over a read in the same cycle.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      result_reg <= RESULT_RESET;
      done_n_out <= 1'b1;
    end else if (conv_done) begin
      result_reg <= sar_result_in;
      done_n_out <= 1'b0;
    end else if (rd_fall) begin
      done_n_out <= 1'b1;
    end
  end

  // Bus drive: on one cycle after a falling read, off one cycle after the rise.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      data_bus_lines_out    <= RESULT_RESET;
      data_bus_lines_oe_out <= 1'b0;
    end else begin
      data_bus_lines_out <= result_reg;
      if (chip_sel_n_in || rd_rise) begin
        data_bus_lines_oe_out <= 1'b0;
      end else if (rd_fall) begin
        data_bus_lines_oe_out <= 1'b1;
      end
    end
  end

  a_read_clears_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
    rd_fall && !conv_done |=> done_n_out) else $error("flag not cleared by read");
  a_done_sets_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
    conv_done |=> !done_n_out && result_reg == $past(sar_result_in)) else $error("flag not set");
  a_read_drives_bus: assert property (@(posedge mclk_in) disable iff (rst_in)
    rd_fall |=> data_bus_lines_oe_out) else $error("bus not driven on read");
  a_release_bus: assert property (@(posedge mclk_in) disable iff (rst_in)
    rd_rise |=> !data_bus_lines_oe_out) else $error("bus not released");
  a_cs_high_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
    chip_sel_n_in |=> !data_bus_lines_oe_out) else $error("bus driven with chip select high");
  a_int_acq_start: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_reg == SEQ_IDLE && wr_rise && !pwr_next[1] && !data_bus_lines_in[ACQ_SEL_POS]
    |=> state_reg == SEQ_ACQ_INT) else $error("internal acquisition not started");
  a_pd_no_start: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_reg == SEQ_IDLE && wr_rise && pwr_next[1]
    |=> state_reg == SEQ_IDLE) else $error("power-down write started a conversion");
  a_ext_acq_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_reg == SEQ_ACQ_EXT && !wr_rise |=> state_reg == SEQ_ACQ_EXT) else $error("tracking ended early");
  a_ext_acq_end: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_reg == SEQ_ACQ_EXT && wr_rise |=> state_reg == SEQ_CONVERT) else $error("second write ignored");
  a_acq_six_clocks: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_reg == SEQ_ACQ_INT && tick && tick_cnt_reg == 4'(ACQ_CONV_CLOCKS - 1)
    |=> state_reg == SEQ_CONVERT) else $error("acquisition length wrong");
  a_result_stable: assert property (@(posedge mclk_in) disable iff (rst_in)
    !conv_done |=> $stable(result_reg)) else $error("result changed without conversion");

  c_int_conv: cover property (@(posedge mclk_in) state_reg == SEQ_ACQ_INT ##[1:400] conv_done);
  c_ext_conv: cover property (@(posedge mclk_in) state_reg == SEQ_ACQ_EXT ##[1:400] conv_done);
  c_read: cover property (@(posedge mclk_in) !done_n_out ##[1:50] rd_fall);
endmodule : aphs_host_seq

// [verif/aphs_host_model.sv]
/*
  Bus host model: chip select, write and read strobes, control byte and a 2 MHz clock pin.
  Assumes the bench resolves the shared data bus from both drivers.
*/
module aphs_host_model (
  input  wire logic   mclk_in,
  output logic        cs_n_out     = 1'b1,
  output logic        wr_n_out     = 1'b1,
  output logic        rd_n_out     = 1'b1,
  output logic        conv_clk_out = 1'b0,
  output logic        drive_out    = 1'b0,
  output logic [11:0] data_out     = 12'h000
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div_reg = 4'h0;

  // The clock pin runs free, as a host oscillator would.
  always @(posedge mclk_in) begin
    div_reg <= (div_reg == 4'h9) ? 4'h0 : div_reg + 4'h1;
    if (div_reg == 4'h9) begin
      conv_clk_out <= ~conv_clk_out;
    end
  end

  // Chip select and data stay put until the edge after the strobe rises.
  task automatic write_ctrl(input logic [7:0] byte_val, input logic sel_n);
    @(posedge mclk_in);
    cs_n_out <= sel_n;
    wr_n_out <= 1'b0;
    drive_out <= 1'b1;
    data_out <= {4'h0, byte_val};
    @(posedge mclk_in);
    wr_n_out <= 1'b1;
    @(posedge mclk_in);
    cs_n_out <= 1'b1;
    drive_out <= 1'b0;
  endtask : write_ctrl

  task automatic read_bus(input logic sel_n);
    @(posedge mclk_in);
    cs_n_out <= sel_n;
    rd_n_out <= 1'b0;
    repeat (4) @(posedge mclk_in);
    rd_n_out <= 1'b1;
    @(posedge mclk_in);
    cs_n_out <= 1'b1;
  endtask : read_bus
endmodule : aphs_host_model

// [verif/tb_top.sv]
/*
  Self-checking bench of the host sequencer: control writes, conversions and reads.
  Assumes the host model file is compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import aphs_pkg::*;
  // Period of the host model's conversion clock pin, in system clock cycles.
  localparam int HOST_CLK_CYCLES = 20;
  logic        mclk_in = 1'b0;
  logic        rst_in  = 1'b1;
  logic [11:0] sar_reg = 12'h000;
  logic [11:0] fill_reg = 12'h5a5;
  logic        oe_prev = 1'b0;
  logic        int_exp = 1'b0;
  logic [11:0] exp_q[$];
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  wire logic        cs_n, wr_n, rd_n, cclk, h_drv, oe, done_n, trk, cnv, int_sel, stby, full, range_sel, pol;
  wire logic [11:0] h_data, d_out;
  wire logic [2:0]  chan;
  // A floating bus shows a changing pattern so a missed release cannot pass.
  wire logic [11:0] bus = oe ? d_out : (h_drv ? h_data : fill_reg);

  always #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) fill_reg <= ~fill_reg;

  aphs_host_model host (.mclk_in(mclk_in), .cs_n_out(cs_n), .wr_n_out(wr_n), .rd_n_out(rd_n),
    .conv_clk_out(cclk), .drive_out(h_drv), .data_out(h_data));
  aphs_host_seq dut (.mclk_in(mclk_in), .rst_in(rst_in), .chip_sel_n_in(cs_n), .wr_n_in(wr_n),
    .rd_n_in(rd_n), .conv_clk_pin_in(cclk), .data_bus_lines_in(bus), .sar_result_in(sar_reg),
    .data_bus_lines_out(d_out), .data_bus_lines_oe_out(oe), .done_n_out(done_n),
    .tracking_out(trk), .converting_out(cnv), .int_clk_sel_out(int_sel),
    .standby_powerdown_out(stby), .full_powerdown_out(full), .range_sel_out(range_sel),
    .polarity_sel_out(pol), .channel_sel_out(chan));

  task automatic check_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_word(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic report_and_stop;
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // Each new bus drive is matched against the oldest noted result.
  always @(negedge mclk_in) begin
    oe_prev <= oe;
    if (oe && !oe_prev) begin
      if (exp_q.size() == 0) check_bit("unexpected_drive", 1'b0, oe);
      else check_word("read_data", exp_q.pop_front(), bus);
    end
  end

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic check_ctrl(input logic [7:0] ctl);
    check_bit("range", ctl[RANGE_POS], range_sel);
    check_bit("polarity", ctl[POLARITY_POS], pol);
    check_word("channel", {9'h000, ctl[2:0]}, {9'h000, chan});
    check_bit("standby", ctl[7:6] == PWR_STANDBY, stby);
    check_bit("full", ctl[7:6] == PWR_FULL, full);
    check_bit("int_clk", int_exp, int_sel);
  endtask : check_ctrl

  task automatic conv_cycle(input logic [7:0] ctl);
    logic [11:0] v;
    int i;
    int n;
    int p;
    v = 12'($urandom);
    p = int_exp ? INT_CLK_DIV : HOST_CLK_CYCLES;
    @(posedge mclk_in);
    sar_reg <= v;
    host.write_ctrl(ctl, 1'b0);
    repeat (3) @(negedge mclk_in);
    check_bit("tracking", 1'b1, trk);
    if (ctl[ACQ_SEL_POS]) begin
      repeat (40) @(negedge mclk_in);
      check_bit("held_tracking", 1'b1, trk);
      check_bit("no_convert", 1'b0, cnv);
      host.write_ctrl(ctl, 1'b0);
      repeat (2) @(negedge mclk_in);
    end else begin
      for (n = 2; n < 400; n++) begin
        @(negedge mclk_in);
        if (trk !== 1'b1) break;
      end
      // The first tick after a clock mode change may still come from the old clock, hence the slack.
      check_bit("acq_length", 1'b1, n >= (ACQ_CONV_CLOCKS - 2) * p + 2 && n <= ACQ_CONV_CLOCKS * p);
    end
    check_bit("acq_ended", 1'b0, trk);
    check_bit("converting", 1'b1, cnv);
    // Bounded wait; the host does not start again before completion.
    for (i = 0; i < 2000 && done_n !== 1'b0; i++) @(negedge mclk_in);
    check_bit("done_n_low", 1'b0, done_n);
    repeat (2) begin
      exp_q.push_back(v);
      host.read_bus(1'b0);
      check_bit("done_n_high", 1'b1, done_n);
      @(negedge mclk_in);
      check_bit("released", 1'b0, oe);
    end
    check_ctrl(ctl);
  endtask : conv_cycle

  initial begin
    logic [1:0] codes [4];
    logic [7:0] ctl;
    codes = '{PWR_NORMAL_INT, PWR_STANDBY, PWR_FULL, PWR_NORMAL_EXT};
    void'($urandom(32'h313e));
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(negedge mclk_in);
    check_bit("done_n_reset", 1'b1, done_n);
    foreach (codes[k]) begin
      ctl = {codes[k], 1'b0, 5'($urandom)};
      if (!codes[k][1]) begin
        int_exp = codes[k][0];
        conv_cycle(ctl);
      end else begin
        host.write_ctrl(ctl, 1'b0);
        repeat (3) @(negedge mclk_in);
        check_bit("pd_idle", 1'b0, trk);
        check_ctrl(ctl);
      end
    end
    ctl = {PWR_NORMAL_EXT, 1'b1, 5'($urandom)};
    conv_cycle(ctl);
    host.write_ctrl({PWR_NORMAL_INT, 1'b0, ~ctl[4:0]}, 1'b1);
    repeat (3) @(negedge mclk_in);
    check_bit("cs_high_write", 1'b0, trk);
    check_bit("cs_high_range", ctl[RANGE_POS], range_sel);
    check_ctrl(ctl);
    host.read_bus(1'b1);
    report_and_stop();
  end
endmodule : tb_top
